// File: core/pcv_ctrl.sv
// Power, clock and vector map control: modes, gating, divider.
// Assumes software writes are single-cycle strobes in the processor clock domain.
module pcv_ctrl (
  // Clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  // Software control and PLL status
  input  wire logic                       ctrl_we_i,
  input  wire pcv_pkg::pcv_ctrl_type      ctrl_wdata_i,
  input  wire logic                       pll_running_i,
  // Wake sources
  input  wire logic                       irq_any_i,
  input  wire logic                       irq_clockless_i,
  // Outputs
  output logic                            map_sram_o,
  output logic [pcv_pkg::NUM_PERIPH-1:0]  periph_en_o,
  output pcv_pkg::pcv_gate_type           gate_o,
  output logic                            pclk_en_o,
  output logic                            idle_req_o,
  output logic                            pdown_req_o,
  output pcv_pkg::pcv_mode_type           mode_o
);
  import pcv_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    pcv_mode_type          mode;
    pcv_ctrl_type          ctrl;
    logic [1:0]            div_act;
    logic [1:0]            div_cnt;
    logic [WAKE_W-1:0]     wake_cnt;
    pcv_gate_type          gate;
    logic                  pclk_en;
  } pcv_state_type;

  pcv_state_type st_q, st_d;

  function automatic logic [1:0] div_last(input logic [1:0] sel);
    case (sel)
      DIV_BY1: div_last = 2'h0;
      DIV_BY2: div_last = 2'h1;
      default: div_last = 2'h3;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    if (ctrl_we_i && st_q.mode == PCV_RUN) begin
      st_d.ctrl = ctrl_wdata_i;
      if (ctrl_wdata_i.div_sel == 2'h3) begin
        st_d.ctrl.div_sel = st_q.ctrl.div_sel;
      end
    end
    // Divider: switch only when the old period completes
    if (st_q.div_cnt >= div_last(st_q.div_act)) begin
      st_d.div_cnt = 2'h0;
      st_d.div_act = st_q.ctrl.div_sel;
      st_d.pclk_en = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 2'h1;
      st_d.pclk_en = 1'b0;
    end
    case (st_q.mode)
      PCV_RUN: begin
        if (st_q.ctrl.pdown_req) begin
          st_d.mode = PCV_PDOWN;
        end else if (st_q.ctrl.idle_req) begin
          st_d.mode = PCV_IDLE;
        end
      end
      PCV_IDLE: begin
        if (irq_any_i) begin
          st_d.mode = PCV_RUN;
          st_d.ctrl.idle_req = 1'b0;
        end
      end
      PCV_PDOWN: begin
        if (irq_clockless_i) begin
          st_d.mode = PCV_WAKE;
          st_d.wake_cnt = '0;
          st_d.ctrl.pdown_req = 1'b0;
        end
      end
      PCV_WAKE: begin
        if (st_q.wake_cnt == WAKE_W'(WAKE_CYCLES - 1)) begin
          st_d.mode = PCV_RUN;
        end else begin
          st_d.wake_cnt = st_q.wake_cnt + WAKE_W'(1);
        end
      end
      default: st_d.mode = PCV_RUN;
    endcase
    // Gates follow the next mode so outputs are registered
    st_d.gate.core_clk_en   = (st_d.mode == PCV_RUN);
    st_d.gate.periph_clk_en = (st_d.mode != PCV_PDOWN);
    st_d.gate.osc_en        = (st_d.mode != PCV_PDOWN);
    st_d.gate.pll_keep      = pll_running_i && st_d.mode != PCV_PDOWN;
    st_d.gate.pin_hold      = (st_d.mode == PCV_PDOWN);
    if (st_d.mode == PCV_PDOWN) begin
      st_d.pclk_en = 1'b0;
    end
    if (reset_i) begin
      st_d          = '0;
      st_d.mode     = PCV_RUN;
      st_d.ctrl.periph_en = PERIPH_EN_RESET;
      st_d.ctrl.map_sel   = MAP_FLASH;
      st_d.ctrl.div_sel   = DIV_RESET;
      st_d.div_act  = DIV_RESET;
      st_d.gate.core_clk_en   = 1'b1;
      st_d.gate.periph_clk_en = 1'b1;
      st_d.gate.osc_en        = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st_q <= st_d;
  end

  assign map_sram_o  = st_q.ctrl.map_sel;
  assign periph_en_o = st_q.ctrl.periph_en;
  assign gate_o      = st_q.gate;
  assign pclk_en_o   = st_q.pclk_en;
  assign idle_req_o  = st_q.ctrl.idle_req;
  assign pdown_req_o = st_q.ctrl.pdown_req;
  assign mode_o      = st_q.mode;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence pd_wake_s;
    st_q.mode == PCV_PDOWN && irq_clockless_i;
  endsequence

  // Writes count only while running; a stopped core cannot issue them
  sequence run_write_s;
    ctrl_we_i && mode_o == PCV_RUN;
  endsequence

  sequence half_rate_s;
    !pclk_en_o ##1 (pclk_en_o || mode_o == PCV_PDOWN);
  endsequence

  idle_core_off_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_IDLE |-> !gate_o.core_clk_en && gate_o.periph_clk_en)
    else $error("core clock running in idle");
  idle_wake_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_IDLE && irq_any_i |=> mode_o == PCV_RUN && !idle_req_o)
    else $error("idle not ended by interrupt");
  pdown_osc_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_PDOWN |-> !gate_o.osc_en && gate_o.pin_hold && !pclk_en_o)
    else $error("clock alive in power-down");
  pdown_stay_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_PDOWN && !irq_clockless_i |=> mode_o == PCV_PDOWN)
    else $error("power-down left without wake source");
  wake_timer_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pd_wake_s |=> mode_o == PCV_WAKE [*8])
    else $error("wake timer skipped");
  ctrl_kept_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_PDOWN |=> $stable(periph_en_o) && $stable(map_sram_o))
    else $error("state lost in power-down");
  pll_idle_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_IDLE && $past(pll_running_i) |-> gate_o.pll_keep)
    else $error("pll dropped in idle");
  div_reset_a: assert property (@(posedge core_clk_i)
    reset_i |=> st_q.div_act == DIV_BY4 && st_q.ctrl.div_sel == DIV_BY4)
    else $error("divider not by four after reset");
  pclk_space_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pclk_en_o && st_q.div_act == DIV_BY4 && mode_o != PCV_PDOWN
      |=> !pclk_en_o [*3])
    else $error("short peripheral clock period");
  map_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    run_write_s |=> map_sram_o == $past(ctrl_wdata_i.map_sel))
    else $error("vector map write lost");
  periph_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    run_write_s |=> periph_en_o == $past(ctrl_wdata_i.periph_en))
    else $error("peripheral enable write lost");
  write_refused_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ctrl_we_i && mode_o != PCV_RUN |=> $stable(map_sram_o) && $stable(periph_en_o))
    else $error("write taken while stopped");
  div_code_keep_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ctrl_we_i && mode_o == PCV_RUN && ctrl_wdata_i.div_sel == 2'h3 |=> $stable(st_q.ctrl.div_sel))
    else $error("unused divider code taken");
  pclk_by1_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st_q.div_act == DIV_BY1 |=> pclk_en_o || mode_o == PCV_PDOWN)
    else $error("full rate pulse missing");
  pclk_by2_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pclk_en_o && st_q.div_act == DIV_BY2 |=> half_rate_s)
    else $error("half rate period wrong");
  pclk_by4_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pclk_en_o && st_q.div_act == DIV_BY4 |-> ##4 (pclk_en_o || mode_o == PCV_PDOWN))
    else $error("quarter rate pulse missing");
  pdown_entry_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_RUN && pdown_req_o |=> mode_o == PCV_PDOWN)
    else $error("power-down request ignored");
  idle_entry_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_RUN && idle_req_o && !pdown_req_o |=> mode_o == PCV_IDLE)
    else $error("idle request ignored");
  idle_stay_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_IDLE && !irq_any_i |=> mode_o == PCV_IDLE)
    else $error("idle left without interrupt");
  idle_clocks_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_IDLE |-> gate_o.osc_en && !gate_o.pin_hold)
    else $error("idle stopped the oscillator");
  run_clocks_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_RUN |-> gate_o.core_clk_en && gate_o.periph_clk_en && gate_o.osc_en)
    else $error("clock gated while running");
  pdown_gates_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_PDOWN |-> !gate_o.core_clk_en && !gate_o.periph_clk_en && !gate_o.pll_keep)
    else $error("clock enabled in power-down");
  pin_release_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o != PCV_PDOWN |-> !gate_o.pin_hold)
    else $error("pins held outside power-down");
  wake_clear_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pd_wake_s |=> !pdown_req_o && gate_o.osc_en)
    else $error("power-down request not cleared");
  wake_core_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_WAKE |-> !gate_o.core_clk_en)
    else $error("core clocked before wake done");
  wake_count_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_WAKE && st_q.wake_cnt != WAKE_W'(WAKE_CYCLES - 1) |=> mode_o == PCV_WAKE)
    else $error("wake ended early");
  wake_exit_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mode_o == PCV_WAKE && st_q.wake_cnt == WAKE_W'(WAKE_CYCLES - 1) |=> mode_o == PCV_RUN)
    else $error("wake did not end");
endmodule : pcv_ctrl

// File: core/pcv_pkg.sv
// Package for the power, clock and vector map control block.
// Assumes one processor clock domain and a synchronous active-high reset.
package pcv_pkg;
  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_PERIPH    = 8;
  localparam int unsigned WAKE_TIME_NS  = 25600;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned WAKE_CYCLES   = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_W        = 11;
  localparam logic [1:0]  DIV_BY1       = 2'h1;
  localparam logic [1:0]  DIV_BY2       = 2'h2;
  localparam logic [1:0]  DIV_BY4       = 2'h0;
  localparam logic [1:0]  DIV_RESET     = DIV_BY4;
  localparam logic [7:0]  PERIPH_EN_RESET = 8'hFF;
  localparam logic        MAP_FLASH     = 1'b0;
  localparam logic        MAP_SRAM      = 1'b1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PCV_RUN, PCV_IDLE, PCV_PDOWN, PCV_WAKE} pcv_mode_type;

  typedef struct packed {
    logic               idle_req;
    logic               pdown_req;
    logic [1:0]         div_sel;
    logic               map_sel;
    logic [NUM_PERIPH-1:0] periph_en;
  } pcv_ctrl_type;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic pll_keep;
    logic pin_hold;
  } pcv_gate_type;
endpackage : pcv_pkg

// File: dv/testbench.sv
// Self-checking bench for the power, clock and vector map control block.
// Assumes pcv_pkg and pcv_ctrl are compiled first; inputs change on falling edges.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pcv_pkg::*;

  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic                  clk    = 1'b0;
  logic                  rst    = 1'b1;
  logic                  we     = 1'b0;
  logic                  pll    = 1'b0;
  logic                  irq    = 1'b0;
  logic                  irq_cl = 1'b0;
  pcv_ctrl_type          wd     = '0;
  pcv_ctrl_type          cur;
  pcv_ctrl_type          bad;
  logic                  map_o;
  logic [NUM_PERIPH-1:0] pen_o;
  pcv_gate_type          gate;
  logic                  pclk;
  logic                  idl;
  logic                  pdn;
  pcv_mode_type          mode;
  logic [1:0]            ediv;
  logic [1:0]            codes [4] = '{DIV_BY1, DIV_BY2, 2'h3, DIV_BY4};
  int                    fail_count = 0;
  int                    num_checks = 0;
  int                    cyc        = 0;

  always #12.5 clk = ~clk;

  pcv_ctrl pcv_ctrl_i (.core_clk_i(clk), .reset_i(rst), .ctrl_we_i(we), .ctrl_wdata_i(wd),
    .pll_running_i(pll), .irq_any_i(irq), .irq_clockless_i(irq_cl), .map_sram_o(map_o),
    .periph_en_o(pen_o), .gate_o(gate), .pclk_en_o(pclk), .idle_req_o(idl),
    .pdown_req_o(pdn), .mode_o(mode));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  function automatic int div_of(input logic [1:0] c);
    return (c == DIV_BY1) ? 1 : (c == DIV_BY2) ? 2 : 4;
  endfunction

  task automatic wr(input pcv_ctrl_type v);
    @(negedge clk);
    we = 1'b1;
    wd = v;
    @(negedge clk);
    we = 1'b0;
  endtask

  // Spacing of peripheral clock enables, settled well after any change
  task automatic period(input int exp);
    int n;
    n = 0;
    repeat (8) @(negedge clk);
    while (pclk !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pclk !== 1'b1 && n < 8);
    check(n[15:0], exp[15:0], "pclk period");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(72));
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check(map_o, MAP_FLASH, "map reset");
    check(pen_o, PERIPH_EN_RESET, "periph reset");
    check(gate, 5'b11100, "gate reset");
    period(4);
    cur = '0;
    ediv = DIV_BY4;
    for (int i = 0; i < 8; i++) begin
      cur.map_sel = 1'($urandom);
      cur.periph_en = NUM_PERIPH'($urandom);
      cur.div_sel = (i < 4) ? codes[i] : 2'($urandom_range(0, 3));
      if (cur.div_sel != 2'h3) ediv = cur.div_sel;
      wr(cur);
      @(negedge clk);
      check(map_o, cur.map_sel, "map");
      check(pen_o, cur.periph_en, "periph");
      period(div_of(ediv));
    end
    pll = 1'b1;
    cur.idle_req = 1'b1;
    wr(cur);
    cur.idle_req = 1'b0;
    repeat (2) @(negedge clk);
    check(mode, PCV_IDLE, "idle mode");
    check(gate, 5'b01110, "idle gates");
    check(idl, 1'b1, "idle req");
    bad = cur;
    bad.map_sel = ~cur.map_sel;
    wr(bad);
    irq = 1'b1;
    repeat (2) @(negedge clk);
    irq = 1'b0;
    check(mode, PCV_RUN, "idle wake");
    check(idl, 1'b0, "idle clear");
    check(map_o, cur.map_sel, "write in idle");
    pll = 1'b0;
    cur.pdown_req = 1'b1;
    wr(cur);
    cur.pdown_req = 1'b0;
    repeat (2) @(negedge clk);
    check(mode, PCV_PDOWN, "pdown mode");
    check(gate, 5'b00001, "pdown gates");
    check(pen_o, cur.periph_en, "pdown retain");
    irq = 1'b1;
    repeat (4) @(negedge clk);
    irq = 1'b0;
    check(mode, PCV_PDOWN, "clocked irq");
    irq_cl = 1'b1;
    @(negedge clk);
    irq_cl = 1'b0;
    check(mode, PCV_WAKE, "wake start");
    check(pdn, 1'b0, "pdown clear");
    repeat (1000) @(negedge clk);
    check(mode, PCV_WAKE, "wake hold");
    repeat (30) @(negedge clk);
    check(mode, PCV_RUN, "wake done");
    cur.idle_req  = 1'b1;
    cur.pdown_req = 1'b1;
    cur.div_sel   = DIV_BY1;
    wr(cur);
    cur.idle_req  = 1'b0;
    cur.pdown_req = 1'b0;
    repeat (2) @(negedge clk);
    check(mode, PCV_PDOWN, "pdown over idle");
    check(pdn, 1'b1, "pdown req held");
    // Reset from power-down with the divider left at full rate
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check(mode, PCV_RUN, "reset exit");
    check(idl, 1'b0, "idle req re-reset");
    check(map_o, MAP_FLASH, "map re-reset");
    check(pen_o, PERIPH_EN_RESET, "periph re-reset");
    check(gate, 5'b11100, "gate re-reset");
    period(4);
    wrap_up();
  end
endmodule // testbench
